// file: inc/rtc_pkg.sv
// Purpose: shared constants and types for the alarm and serial register block
// Assumes: 100 MHz system clock
// Notes: slave identifier value is arbitrary
package rtc_pkg;
    // register map
    localparam logic [7:0] A_STATUS = 8'h07;
    localparam logic [7:0] A_INTCTL = 8'h08;
    localparam logic [7:0] A_ALM_FIRST = 8'h0c;
    localparam logic [7:0] A_ALM_LAST = 8'h11;
    localparam logic [7:0] A_USER0 = 8'h12;
    localparam logic [7:0] A_USER1 = 8'h13;
    localparam logic [7:0] A_WRAP = 8'h13;
    localparam logic [7:0] A_FIRST = 8'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // field positions
    localparam int ALM_N = 6;
    localparam int ENABLE_BIT = 7;
    localparam int ST_AUTOCLR_BIT = 7;
    localparam int ST_ALARM_BIT = 2;
    localparam int INT_IM_BIT = 7;
    localparam int INT_ALARM_FUNCTION_ON_BIT = 6;
    localparam int FO_LSB = 0;
    localparam int FO_W = 4;
    // device identifier, arbitrary value
    localparam logic [6:0] SLAVE_ID = 7'h2a;
    // timing
    localparam int PULSE_MS = 250;
    localparam int CLK_KHZ = 100000;
    localparam int PULSE_CYCLES = PULSE_MS * CLK_KHZ;
    localparam int POWERUP_CYCLES = 64;
    // running time, same order as the alarm bytes
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] dow;
    } time_fields_t;
    // one received register write
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } wr_item_t;
    typedef enum logic [2:0] {SER_IDLE, SER_DEVICE, SER_WORD, SER_WRITE, SER_READ} ser_state_t;
endpackage

// file: src/rtc_alarm_serial.sv
// Purpose: alarm compare, user bytes and two-wire slave register port
// Assumes: time_now already shows the new time in the cycle time_tick is high
// Notes: scl and sda are sampled by clk; sda is open drain (oe high pulls low)
//
// Overview of operation
// - alarm byte msb enables that field; low bits hold the compare value
// - alarm fields are seconds, minutes, hours, date, month, weekday; no year
// - alarm triggers when all enabled fields equal running time
// - single mode: match sets flag, interrupt held low until flag cleared
// - repeat mode: interrupt pulses on every later match without software
// - writing zero to the flag bit in status clears it
// - with auto clear set, reading status clears the flag
// - evaluate alarm at the time update producing the match
// - repeat mode still sets the flag; pulses ignore flag state
// - two read/write user bytes at 12h and 13h
// - device is slave only; master starts transfers and drives clock
// - bytes are shifted msb first in both directions
// - data changes only with clock low; else start or stop
// - data pin is input after power up; early starts ignored
// - all traffic ignored until a start condition is seen
// - stop ends every operation and returns the port to standby
// - transmitter releases data after eight bits; receiver acks ninth clock
// - device acks its address, word address and write data bytes
// - seven upper address bits must equal the identifier to ack
// - address lsb one selects read, zero selects write
// - word address follows slave byte; pointer resets to zero
// - read pointer increments per byte and wraps 13h to 00h
// - repeat mode pulse is 250 ms active low
// - nonzero frequency select takes the pin and disables the alarm
`timescale 1ns/100ps
module rtc_alarm_serial #(
    parameter int unsigned PULSE_CYCLES = rtc_pkg::PULSE_CYCLES,
    parameter int unsigned POWERUP_CYCLES = rtc_pkg::POWERUP_CYCLES
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic scl_pin, // serial clock from master
    input wire logic sda_in, // serial data wire level
    input wire logic time_tick, // one-cycle pulse on time update
    input wire rtc_pkg::time_fields_t time_now, // running time
    input wire logic fout_level, // frequency output level
    output logic sda_out, // data output value, always low
    output logic sda_oe, // pull data line low
    output logic irq_n, // interrupt or frequency pin, active low
    output logic [3:0] fout_select, // frequency select for generator
    output logic alarm_flag // alarm status flag
);
    // synchronisers and edge detection
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    // power-up hold-off
    logic [7:0] pwr_cnt;
    // serial engine
    rtc_pkg::ser_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic [7:0] next_byte;
    logic ack_phase;
    logic master_nack;
    logic status_read;
    // write buffer
    logic push_valid;
    logic push_ready;
    rtc_pkg::wr_item_t push_item;
    rtc_pkg::wr_item_t buf_mem [2];
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_cnt;
    logic pop_valid;
    logic pop_ready;
    logic pop;
    rtc_pkg::wr_item_t wr;
    // registers
    logic [7:0] alarm_reg [rtc_pkg::ALM_N];
    logic [7:0] user_reg [2];
    logic [7:0] int_ctl;
    logic auto_clear;
    // alarm
    logic [8*rtc_pkg::ALM_N-1:0] time_vec;
    logic [rtc_pkg::ALM_N-1:0] fld_en;
    logic [rtc_pkg::ALM_N-1:0] fld_hit;
    logic alarm_match;
    logic fo_active;
    logic alarm_fire;
    logic flag_clr;
    logic next_flag;
    logic [24:0] pulse_cnt;
    logic [24:0] next_pulse_cnt;

    // two flops per pin, third stage only for edge detect
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_pin};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    // bus conditions; sda edges while scl high are start or stop
    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;

    // power-up hold-off counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_cnt <= 8'(POWERUP_CYCLES);
        end else if (pwr_cnt != 8'h00) begin
            pwr_cnt <= pwr_cnt - 8'h01;
        end
    end

    // pointer increment with wrap, and register read mux
    assign next_ptr = (ptr >= rtc_pkg::A_WRAP) ? rtc_pkg::A_FIRST : ptr + 8'h01;
    always_comb begin
        logic [7:0] off;
        off = ptr - rtc_pkg::A_ALM_FIRST;
        next_byte = 8'h00;
        case (ptr)
            rtc_pkg::A_STATUS: begin
                next_byte[rtc_pkg::ST_AUTOCLR_BIT] = auto_clear;
                next_byte[rtc_pkg::ST_ALARM_BIT] = alarm_flag;
            end
            rtc_pkg::A_INTCTL: next_byte = int_ctl;
            rtc_pkg::A_USER0: next_byte = user_reg[0];
            rtc_pkg::A_USER1: next_byte = user_reg[1];
            default: begin
                if (ptr >= rtc_pkg::A_ALM_FIRST && ptr <= rtc_pkg::A_ALM_LAST) begin
                    next_byte = alarm_reg[off[2:0]];
                end
            end
        endcase
    end

    // serial slave engine; open drain, so oe high means pull low
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= rtc_pkg::SER_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            ptr <= rtc_pkg::A_FIRST;
            ack_phase <= 1'b0;
            master_nack <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            push_valid <= 1'b0;
            push_item <= '0;
            status_read <= 1'b0;
        end else begin
            push_valid <= 1'b0;
            status_read <= 1'b0;
            if (start_seen && pwr_cnt == 8'h00) begin
                state <= rtc_pkg::SER_DEVICE;
                cnt <= 4'h0;
                ack_phase <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_seen || state == rtc_pkg::SER_IDLE) begin
                state <= rtc_pkg::SER_IDLE;
                ack_phase <= 1'b0;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (ack_phase) begin
                    if (state == rtc_pkg::SER_READ && sda_s) begin
                        master_nack <= 1'b1;
                    end
                end else begin
                    cnt <= cnt + 4'h1;
                    shreg <= {shreg[6:0], sda_s};
                end
            end else if (scl_fall) begin
                if (ack_phase) begin
                    // end of ninth clock: release and maybe start next byte
                    ack_phase <= 1'b0;
                    sda_oe <= 1'b0;
                    cnt <= 4'h0;
                    if (state == rtc_pkg::SER_READ) begin
                        if (master_nack) begin
                            state <= rtc_pkg::SER_IDLE;
                        end else begin
                            tx <= next_byte;
                            sda_oe <= ~next_byte[7];
                            ptr <= next_ptr;
                            if (ptr == rtc_pkg::A_STATUS && auto_clear) begin
                                status_read <= 1'b1;
                            end
                        end
                    end
                end else if (cnt == 4'h8) begin
                    ack_phase <= 1'b1;
                    master_nack <= 1'b0;
                    case (state)
                        rtc_pkg::SER_DEVICE: begin
                            if (shreg[7:1] == rtc_pkg::SLAVE_ID) begin
                                sda_oe <= 1'b1;
                                state <= shreg[0] ? rtc_pkg::SER_READ : rtc_pkg::SER_WORD;
                            end else begin
                                state <= rtc_pkg::SER_IDLE;
                            end
                        end
                        rtc_pkg::SER_WORD: begin
                            ptr <= shreg;
                            sda_oe <= 1'b1;
                            state <= rtc_pkg::SER_WRITE;
                        end
                        rtc_pkg::SER_WRITE: begin
                            if (push_ready) begin
                                push_valid <= 1'b1;
                                push_item <= '{addr: ptr, data: shreg};
                                ptr <= next_ptr;
                                sda_oe <= 1'b1;
                            end else begin
                                state <= rtc_pkg::SER_IDLE;
                            end
                        end
                        rtc_pkg::SER_READ: sda_oe <= 1'b0;
                        default: state <= rtc_pkg::SER_IDLE;
                    endcase
                end else if (state == rtc_pkg::SER_READ) begin
                    sda_oe <= ~tx[3'd7 - cnt[2:0]];
                end
            end
        end
    end

    // two-entry write buffer; register side yields on time update cycles
    assign push_ready = buf_cnt != 2'h2;
    assign pop_valid = buf_cnt != 2'h0;
    assign pop_ready = ~time_tick;
    assign pop = pop_valid & pop_ready;
    assign wr = buf_mem[buf_rp];

    // buffer storage
    always_ff @(posedge clk) begin
        if (push_valid) begin
            buf_mem[buf_wp] <= push_item;
        end
    end

    // buffer pointers and fill count
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
        end else begin
            if (push_valid) begin
                buf_wp <= ~buf_wp;
            end
            if (pop) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= buf_cnt + {1'b0, push_valid} - {1'b0, pop};
        end
    end

    // control, status and user byte writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_ctl <= rtc_pkg::RESET_BYTE;
            fout_select <= 4'h0;
            auto_clear <= 1'b0;
            user_reg[0] <= rtc_pkg::RESET_BYTE;
            user_reg[1] <= rtc_pkg::RESET_BYTE;
        end else if (pop) begin
            case (wr.addr)
                rtc_pkg::A_INTCTL: begin
                    int_ctl <= wr.data;
                    fout_select <= wr.data[rtc_pkg::FO_LSB +: rtc_pkg::FO_W];
                end
                rtc_pkg::A_STATUS: auto_clear <= wr.data[rtc_pkg::ST_AUTOCLR_BIT];
                rtc_pkg::A_USER0: user_reg[0] <= wr.data;
                rtc_pkg::A_USER1: user_reg[1] <= wr.data;
                default: ;
            endcase
        end
    end

    // alarm bytes and per-field compare
    assign time_vec = time_now;
    for (genvar i = 0; i < rtc_pkg::ALM_N; i++) begin : g_alarm
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                alarm_reg[i] <= rtc_pkg::RESET_BYTE;
            end else if (pop && wr.addr == rtc_pkg::A_ALM_FIRST + 8'(i)) begin
                alarm_reg[i] <= wr.data;
            end
        end
        assign fld_en[i] = alarm_reg[i][rtc_pkg::ENABLE_BIT];
        assign fld_hit[i] = alarm_reg[i][6:0] == time_vec[8*(rtc_pkg::ALM_N-1-i) +: 7];
    end

    // trigger decision at the update cycle
    assign alarm_match = (fld_en != '0) && ((fld_hit | ~fld_en) == '1);
    assign fo_active = int_ctl[rtc_pkg::FO_LSB +: rtc_pkg::FO_W] != 4'h0;
    assign alarm_fire = time_tick & alarm_match & int_ctl[rtc_pkg::INT_ALARM_FUNCTION_ON_BIT] & ~fo_active;

    // flag and pulse next values; a set wins over a clear
    always_comb begin
        flag_clr = status_read;
        if (pop && wr.addr == rtc_pkg::A_STATUS && !wr.data[rtc_pkg::ST_ALARM_BIT]) begin
            flag_clr = 1'b1;
        end
        next_flag = alarm_fire | (alarm_flag & ~flag_clr);
        if (alarm_fire && int_ctl[rtc_pkg::INT_IM_BIT]) begin
            next_pulse_cnt = 25'(PULSE_CYCLES);
        end else if (pulse_cnt != 25'h0) begin
            next_pulse_cnt = pulse_cnt - 25'h1;
        end else begin
            next_pulse_cnt = 25'h0;
        end
    end

    // flag, pulse timer and shared pin
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_flag <= 1'b0;
            pulse_cnt <= 25'h0;
            irq_n <= 1'b1;
        end else begin
            alarm_flag <= next_flag;
            pulse_cnt <= next_pulse_cnt;
            if (fo_active) begin
                irq_n <= fout_level;
            end else if (int_ctl[rtc_pkg::INT_IM_BIT]) begin
                irq_n <= next_pulse_cnt == 25'h0;
            end else begin
                irq_n <= ~next_flag;
            end
        end
    end
endmodule

// file: verification/rtc_alarm_serial_assertions.sv
// Purpose: pin level checks for the alarm and serial port
// Assumes: one clock domain, async active high reset
// Notes: bound into every instance of the block
`timescale 1ns/100ps
module rtc_alarm_serial_assertions #(
    parameter int unsigned PULSE_CYCLES = rtc_pkg::PULSE_CYCLES,
    parameter int unsigned POWERUP_CYCLES = rtc_pkg::POWERUP_CYCLES
) (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic scl_pin, // bus clock
    input wire logic sda_in, // data wire
    input wire logic time_tick, // time update
    input wire rtc_pkg::time_fields_t time_now, // time
    input wire logic fout_level, // freq level
    input wire logic sda_out, // data value
    input wire logic sda_oe, // data pull
    input wire logic irq_n, // irq pin
    input wire logic [3:0] fout_select, // freq select
    input wire logic alarm_flag // flag
);
    int unsigned low_run; // low cycles of irq pin
    int unsigned up_cnt; // cycles since reset
    // length of the current low phase of the irq pin
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_run <= 0;
        end else begin
            low_run <= irq_n ? 0 : low_run + 1;
        end
    end
    // saturating count after reset release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_cnt <= 0;
        end else if (up_cnt < POWERUP_CYCLES) begin
            up_cnt <= up_cnt + 1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // stop: data rises while clock stays high
    sequence stop_seen;
        scl_pin && $past(scl_pin) && $rose(sda_in);
    endsequence
    // device starts pulling the data line
    sequence pull_start;
        $rose(sda_oe);
    endsequence
    a_pull_clock_low:
        assert property (pull_start |-> !scl_pin) else $error("data pulled with clock high");
    a_pull_holds:
        assert property (pull_start |=> sda_oe [*8]) else $error("data pull too short");
    a_stop_release:
        assert property (stop_seen |-> ##5 !sda_oe) else $error("data held after stop");
    a_powerup_quiet:
        assert property (up_cnt < POWERUP_CYCLES |-> !sda_oe) else $error("drive in power up");
    a_flag_from_tick:
        assert property ($rose(alarm_flag) |-> $past(time_tick)) else $error("flag set without tick");
    a_irq_fall_cause:
        assert property ($fell(irq_n) && fout_select == 4'h0 && $past(fout_select) == 4'h0
            |-> $past(time_tick) || $past(time_tick, 2)) else $error("irq fell without tick");
    a_fout_passes:
        assert property (fout_select != 4'h0 && $past(fout_select, 2) != 4'h0 && fout_level == $past(fout_level)
            && fout_level == $past(fout_level, 2) |-> irq_n == fout_level) else $error("irq not fout");
    a_fout_no_alarm:
        assert property (fout_select != 4'h0 && $past(fout_select) != 4'h0 |-> !$rose(alarm_flag))
            else $error("alarm with fout on");
    a_pulse_width:
        assert property ($rose(irq_n) && alarm_flag && fout_select == 4'h0 && $past(fout_select) == 4'h0
            |-> low_run == PULSE_CYCLES) else $error("irq pulse width wrong");
endmodule
bind rtc_alarm_serial rtc_alarm_serial_assertions #(.PULSE_CYCLES(PULSE_CYCLES), .POWERUP_CYCLES(POWERUP_CYCLES))
    rtc_alarm_serial_assertions_i (.clk(clk), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_in(sda_in),
    .time_tick(time_tick), .time_now(time_now), .fout_level(fout_level), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq_n(irq_n), .fout_select(fout_select), .alarm_flag(alarm_flag));

// file: verification/i2c_master_model.sv
// Purpose: two-wire bus master driving the serial port
// Assumes: 160 ns bus clock, pull-up on the data wire
// Notes: clock stands high between frames
`timescale 1ns/100ps
module i2c_master_model (
    output logic scl, // bus clock
    output logic sda_m, // data drive, 1 releases
    input wire logic sda_w // resolved data wire
);
    // bus idles high
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // one bit: data set while clock low, sampled mid high
    task automatic bit_x(input logic b, output logic r);
        #20 sda_m = b;
        #60 scl = 1'b1;
        #40 r = sda_w;
        #40 scl = 1'b0;
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        #20 sda_m = 1'b1;
        #60 scl = 1'b1;
        #40 sda_m = 1'b0;
        #40 scl = 1'b0;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        #20 sda_m = 1'b0;
        #60 scl = 1'b1;
        #40 sda_m = 1'b1;
        #40;
    endtask
    // send a byte msb first, release for the ninth clock
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    // receive a byte msb first, then ack (0) or nack (1)
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(last, r);
    endtask
endmodule

// file: verification/tb_rtc_alarm_serial.sv
// Purpose: self-checking bench for the alarm and serial register block
// Assumes: master model drives clock and data, pull-up on data
// Notes: pulse and power-up counts shortened by parameter
`timescale 1ns/100ps
module tb_rtc_alarm_serial;
    localparam int unsigned PW = 20; // short irq pulse
    logic clk, sys_rst, scl, sda_m, sda_w, time_tick, fout_level, sda_out, sda_oe, irq_n, alarm_flag, ack;
    logic [3:0] fout_select;
    logic [7:0] rb [22];
    rtc_pkg::time_fields_t time_now;
    int miscompares = 0;
    int checked = 0;
    // open-drain data wire with pull-up
    assign sda_w = (sda_oe ? sda_out : 1'b1) & sda_m;
    rtc_alarm_serial #(.PULSE_CYCLES(PW), .POWERUP_CYCLES(8)) rtc_alarm_serial_i (.clk(clk), .sys_rst(sys_rst),
        .scl_pin(scl), .sda_in(sda_w), .time_tick(time_tick), .time_now(time_now), .fout_level(fout_level),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq_n(irq_n), .fout_select(fout_select), .alarm_flag(alarm_flag));
    i2c_master_model i2c_master_model_i (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));
    // system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard, run needs about 130 us
    initial begin
        #600000;
        miscompares++;
        end_sim();
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic sendk(input logic [7:0] d);
        i2c_master_model_i.send(d, ack);
        check("ack", 8'(ack), 8'h01);
    endtask
    // register write, data bytes land at successive addresses
    task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
        i2c_master_model_i.start();
        sendk({rtc_pkg::SLAVE_ID, 1'b0});
        sendk(a);
        foreach (d[i]) begin
            sendk(d[i]);
        end
        i2c_master_model_i.stop();
        cyc(4);
    endtask
    // random read: dummy write, repeated start, n bytes, last one refused
    task automatic rd(input logic [7:0] a, input int n);
        i2c_master_model_i.start();
        sendk({rtc_pkg::SLAVE_ID, 1'b0});
        sendk(a);
        i2c_master_model_i.start();
        sendk({rtc_pkg::SLAVE_ID, 1'b1});
        for (int i = 0; i < n; i++) begin
            i2c_master_model_i.recv(i == n - 1, rb[i]);
        end
        i2c_master_model_i.stop();
    endtask
    // one time update, date and month 1, weekday 3
    task automatic tick(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
        cyc(1);
        time_now = {s, m, h, 8'h01, 8'h01, 8'h03};
        time_tick = 1'b1;
        cyc(1);
        time_tick = 1'b0;
        cyc(1);
    endtask
    task automatic t_reset();
        check("oe", 8'(sda_oe), 8'h00);
        check("sda out", 8'(sda_out), 8'h00);
        check("irq", 8'(irq_n), 8'h01);
        check("fsel", {4'h0, fout_select}, 8'h00);
        cyc(20);
    endtask
    task automatic t_user();
        wr(8'h12, '{8'ha5, 8'h3c});
        rd(8'h12, 22);
        check("user0", rb[0], 8'ha5);
        check("user1", rb[1], 8'h3c);
        check("wrap0", rb[20], 8'ha5);
        check("wrap1", rb[21], 8'h3c);
        rd(8'h12, 1);
        i2c_master_model_i.start();
        sendk({rtc_pkg::SLAVE_ID, 1'b1});
        i2c_master_model_i.recv(1'b1, rb[0]);
        i2c_master_model_i.stop();
        check("current", rb[0], 8'h3c);
        i2c_master_model_i.start();
        i2c_master_model_i.send({7'h2b, 1'b0}, ack);
        check("foreign id", 8'(ack), 8'h00);
        i2c_master_model_i.send(8'h12, ack);
        check("no start", 8'(ack), 8'h00);
        i2c_master_model_i.stop();
    endtask
    task automatic t_single();
        wr(8'h0c, '{8'h00, 8'hb0, 8'h91, 8'h81, 8'h81, 8'h00});
        wr(8'h08, '{8'h40});
        rd(8'h0c, 6);
        check("alarm min", rb[1], 8'hb0);
        check("alarm hour", rb[2], 8'h91);
        check("alarm dow", rb[5], 8'h00);
        tick(8'h59, 8'h29, 8'h11);
        check("early", 8'(alarm_flag), 8'h00);
        tick(8'h00, 8'h30, 8'h11);
        check("flag", 8'(alarm_flag), 8'h01);
        tick(8'h01, 8'h30, 8'h11);
        check("held", 8'(irq_n), 8'h00);
        wr(8'h07, '{8'h00});
        check("cleared", 8'(irq_n), 8'h01);
        tick(8'h00, 8'h30, 8'h12);
        check("hour", 8'(alarm_flag), 8'h00);
    endtask
    task automatic t_auto();
        wr(8'h07, '{8'h80});
        tick(8'h00, 8'h30, 8'h11);
        rd(8'h07, 1);
        check("status", rb[0], 8'h80 | (8'h01 << rtc_pkg::ST_ALARM_BIT));
        check("auto", 8'(alarm_flag), 8'h00);
    endtask
    task automatic t_repeat();
        wr(8'h0c, '{8'hb0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        wr(8'h08, '{8'hc0});
        for (int k = 0; k < 2; k++) begin
            tick(8'h30, 8'h31, 8'h11);
            check("pulse", 8'(irq_n), 8'h00);
            check("rep flag", 8'(alarm_flag), 8'h01);
            cyc(PW - 4);
            check("pulse on", 8'(irq_n), 8'h00);
            cyc(6);
            check("pulse end", 8'(irq_n), 8'h01);
        end
    endtask
    task automatic t_fout();
        wr(8'h07, '{8'h00});
        wr(8'h08, '{8'hc1});
        check("fsel", {4'h0, fout_select}, 8'h01);
        fout_level = 1'b0;
        cyc(4);
        check("fout", 8'(irq_n), 8'h00);
        fout_level = 1'b1;
        tick(8'h30, 8'h31, 8'h11);
        check("no alarm", 8'(alarm_flag), 8'h00);
        check("fout hi", 8'(irq_n), 8'h01);
        wr(8'h08, '{8'h00});
    endtask
    // reset, then the scenarios in turn
    initial begin
        sys_rst = 1'b1;
        time_tick = 1'b0;
        time_now = '0;
        fout_level = 1'b1;
        cyc(6);
        sys_rst = 1'b0;
        t_reset();
        t_user();
        t_single();
        t_auto();
        t_repeat();
        t_fout();
        end_sim();
    end
endmodule
